// ==== shared/crp_params.svh ====
`ifndef CRP_PARAMS_SVH
`define CRP_PARAMS_SVH

// Register byte offsets
`define CRP_OFS_CTRL 8'h00
`define CRP_OFS_THRESH 8'h04
`define CRP_OFS_ACCUM 8'h08
`define CRP_OFS_STATUS 8'h0C
`define CRP_AW 8

// Control fields
`define CRP_CTRL_EN 0
`define CRP_CTRL_BEH_LO 1
`define CRP_CTRL_BEH_HI 2
`define CRP_CTRL_LATCHCFG 3
`define CRP_CTRL_SMBUS 4
`define CRP_CTRL_RST 8
`define CRP_CTRL_ERRCLR 9

// Status fields
`define CRP_STAT_FLAG 0
`define CRP_STAT_ALERT 1
`define CRP_STAT_ERR 2
`define CRP_STAT_LATCH 3
`define CRP_STAT_ST_LO 4
`define CRP_STAT_ST_HI 6
`define CRP_STAT_SLEEP 7

// Reset values
`define CRP_EN_RST 1'h0
`define CRP_BEH_RST 2'h1
`define CRP_LATCHCFG_RST 1'h0
`define CRP_SMBUS_RST 1'h1
`define CRP_ACC_W 16
`define CRP_THRESH_RST 32'hFFFF_FFFF

`endif

// ==== shared/crp_pkg.sv ====
package crp_pkg;

  // Behavior codes
  typedef enum logic [1:0] {
    BEH_REPORT = 2'h0,
    BEH_REP_DISC = 2'h1,
    BEH_DISC_SLEEP = 2'h2,
    BEH_IGNORE = 2'h3
  } crp_beh_t;

  // Policy sequencer, Gray along the action path
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_ALRT = 3'h1,
    ST_PROF = 3'h3,
    ST_OPEN = 3'h2,
    ST_SLP = 3'h6,
    ST_HOLD = 3'h7,
    ST_EVAL = 3'h5
  } crp_state_t;

  // Mode pins
  typedef struct packed {
    logic mode_sel_a;
    logic mode_sel_b;
    logic emulation_enable;
    logic attach_gate_sel;
    logic port_power_enable;
  } crp_pins_t;

  // Actions a behavior imposes once the threshold is reached
  typedef struct packed {
    logic alert;
    logic prof;
    logic sw;
    logic sleep;
  } crp_tgt_t;

  function automatic crp_tgt_t crp_tgt_of(crp_beh_t b);
    crp_tgt_t t;
    t = '0;
    case (b)
      BEH_REPORT: t.alert = 1'b1;
      BEH_REP_DISC: t = '{alert: 1'b1, prof: 1'b1, sw: 1'b1, sleep: 1'b0};
      BEH_DISC_SLEEP: t = '{alert: 1'b0, prof: 1'b1, sw: 1'b1, sleep: 1'b1};
      default: t = '0;
    endcase
    return t;
  endfunction : crp_tgt_of

endpackage : crp_pkg

// ==== src/crp_charge_threshold_flag_a_ctrl.sv ====
// Contract
// [R1] Accumulate and compare only while enabled and in Active; port runs normally till then.
// [R2] Removal or attach events never clear accumulation or threshold flag.
// [R3] Removal then attach before threshold restarts emulation, total keeps counting.
// [R4] Writing a new behavior leaves the accumulated charge untouched.
// [R5] Behavior change before threshold takes effect silently, governs later action.
// [R6] Behavior change after threshold is applied at once per old-to-new transition.
// [R7] Ignore to report asserts alert; to report-disconnect also removes profile, opens switch.
// [R8] Ignore to disconnect-sleep removes profile, opens switch, sleeps, no alert.
// [R9] Report to ignore releases alert; to report-disconnect opens the switch.
// [R10] Report to disconnect-sleep: release alert, remove profile, open switch, sleep.
// [R11] Report-disconnect leaving: ignore releases and re-checks, report re-checks, sleep sleeps.
// [R12] Leaving disconnect-sleep re-checks pins; report alerts; report-disconnect keeps switches open.
// [R13] Re-check restarts emulation only if pins changed and enable emulation.
// [R14] Disable before threshold stops rationing and clears accumulated charge.
// [R15] Disable after threshold clears flag and re-checks mode pins.
// [R16] Alert released on disable only when no other alert source remains.
// [R17] Host should toggle port power enable after such a disable.
// [R18] Threshold_flag_a reset zeroes accumulation; before threshold counting continues from zero.
// [R19] Latched or auto-recovery faults; config bit when SMBus used, else latch pin.
// [R20] Six fault sources all handled by the selected fault mechanism.
// [R21] Threshold action by code: 00 alert, 01 alert+remove+open, 10 sleep path, 11 none.
// [R22] Reset after threshold clears flag, releases alert, re-checks pins if disconnected.
// [R23] In disconnect-sleep monitoring stops and pin changes are ignored.
// [R24] Flag sets in the cycle the total reaches threshold, held until reset/disable.
// [R25] Applied behavior and flag are registered to decode transitions.
`include "crp_params.svh"

module crp_charge_threshold_flag_a_ctrl import crp_pkg::*; #(
  parameter int ACC_W = `CRP_ACC_W,
  parameter int STEP_W = 8
) (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Mode pins and fault pins, asynchronous
  input crp_pins_t mode_pins,
  input logic latch_pin,
  input logic [5:0] fault_pins,
  // Core logic, same clock
  input logic active_state,
  input logic charge_valid,
  input logic [STEP_W-1:0] charge_step,
  input logic removal_evt,
  input logic attach_evt,
  input logic other_alert,
  // Policy outputs
  output logic alert_n,
  output logic profile_remove,
  output logic port_sw_open,
  output logic bypass_sw_block,
  output logic sleep_req,
  output logic monitor_stop,
  output logic mode_reeval,
  output logic emul_restart,
  output logic fault_err,
  output logic fault_latch_mode
);

  if (ACC_W < 8 || ACC_W > 32 || STEP_W < 1 || STEP_W >= ACC_W) begin : g_bad_param
    $error("crp_charge_threshold_flag_a_ctrl: unsupported ACC_W or STEP_W");
  end

  localparam int SW = $bits(crp_pins_t) + 7;

  // Input synchronisers
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  crp_pins_t pins;
  logic latch_pin_s;
  logic [5:0] faults;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {mode_pins, latch_pin, fault_pins};
      sync2_q <= sync1_q;
    end
  end

  assign pins = crp_pins_t'(sync2_q[SW-1:7]);
  assign latch_pin_s = sync2_q[6];
  assign faults = sync2_q[5:0];

  // APB handshake
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic acc_ph;
  logic wr;
  logic wr_ctrl;
  logic [`CRP_AW-1:0] addr;

  assign acc_ph = psel && penable && pready_q;
  assign wr = acc_ph && pwrite;
  assign addr = paddr[`CRP_AW-1:0];
  assign wr_ctrl = wr && (addr == `CRP_OFS_CTRL);

  // Control registers
  logic en_q;
  crp_beh_t beh_cfg_q;
  logic lcfg_q;
  logic smb_q;
  logic [ACC_W-1:0] thr_q;
  logic rst_pls;
  logic en_fall;
  logic err_clr;

  assign rst_pls = wr_ctrl && pwdata[`CRP_CTRL_RST];
  assign en_fall = wr_ctrl && !pwdata[`CRP_CTRL_EN] && en_q;
  assign err_clr = wr_ctrl && pwdata[`CRP_CTRL_ERRCLR];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= `CRP_EN_RST;
      beh_cfg_q <= crp_beh_t'(`CRP_BEH_RST);
      lcfg_q <= `CRP_LATCHCFG_RST;
      smb_q <= `CRP_SMBUS_RST;
      thr_q <= ACC_W'(`CRP_THRESH_RST);
    end else if (wr_ctrl) begin
      en_q <= pwdata[`CRP_CTRL_EN];
      beh_cfg_q <= crp_beh_t'(pwdata[`CRP_CTRL_BEH_HI:`CRP_CTRL_BEH_LO]);
      lcfg_q <= pwdata[`CRP_CTRL_LATCHCFG];
      smb_q <= pwdata[`CRP_CTRL_SMBUS];
    end else if (wr && addr == `CRP_OFS_THRESH) begin
      thr_q <= pwdata[ACC_W-1:0];
    end
  end

  // Accumulator and threshold flag
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic [ACC_W:0] acc_sum;
  logic acc_en, flag_q, flag_set, flag_clr;
  crp_state_t st_q;

  assign acc_en = en_q && active_state && charge_valid; // see [R1]
  assign acc_sum = {1'b0, acc_q} + (ACC_W+1)'(charge_step);

  always_comb begin
    acc_d = acc_q;
    if (rst_pls || (en_fall && !flag_q)) begin
      acc_d = '0; // see [R14] see [R18]
    end else if (acc_en) begin
      acc_d = acc_sum[ACC_W] ? '1 : acc_sum[ACC_W-1:0];
    end
  end

  // Removal and attach do not touch the total
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d; // see [R2] see [R4]
    end
  end

  assign flag_set = en_q && active_state && !flag_q && st_q == ST_RUN && !rst_pls
                    && !en_fall && acc_d >= thr_q; // see [R24] see [R1]
  assign flag_clr = flag_q && (rst_pls || en_fall);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (flag_set) begin
      flag_q <= 1'b1; // see [R24]
    end else if (flag_clr) begin
      flag_q <= 1'b0; // see [R15] see [R22]
    end
  end

  // Policy sequencer
  crp_beh_t beh_q;
  crp_tgt_t tgt_q;
  logic alert_q, prof_q, sw_q, sleep_q, rel_q, rel_now;
  crp_pins_t snap_q;
  logic changed;

  assign changed = flag_q && st_q == ST_HOLD && beh_cfg_q != beh_q;
  assign rel_now = rel_q || (sleep_q && !tgt_q.sleep) || !en_q; // see [R15]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RUN;
      beh_q <= crp_beh_t'(`CRP_BEH_RST);
      tgt_q <= '0;
      alert_q <= 1'b0;
      prof_q <= 1'b0;
      sw_q <= 1'b0;
      sleep_q <= 1'b0;
      rel_q <= 1'b0;
    end else if (flag_clr && st_q != ST_RUN) begin
      tgt_q <= '0; // see [R15] see [R16] see [R22]
      st_q <= ST_ALRT;
    end else begin
      case (st_q)
        ST_RUN: begin
          beh_q <= beh_cfg_q; // see [R5]
          if (flag_set) begin
            tgt_q <= crp_tgt_of(beh_cfg_q); // see [R21]
            st_q <= ST_ALRT;
          end
        end
        ST_HOLD: begin
          if (changed) begin
            beh_q <= beh_cfg_q; // see [R25]
            tgt_q <= crp_tgt_of(beh_cfg_q); // see [R6]
            st_q <= ST_ALRT;
          end
        end
        ST_ALRT: begin
          alert_q <= tgt_q.alert; // see [R7] see [R9] see [R12]
          rel_q <= 1'b0;
          st_q <= ST_PROF;
        end
        ST_PROF: begin
          prof_q <= tgt_q.prof; // see [R8] see [R10]
          rel_q <= rel_q || (prof_q && !tgt_q.prof);
          st_q <= ST_OPEN;
        end
        ST_OPEN: begin
          sw_q <= tgt_q.sw; // see [R7] see [R9]
          rel_q <= rel_q || (sw_q && !tgt_q.sw);
          st_q <= ST_SLP;
        end
        ST_SLP: begin
          sleep_q <= tgt_q.sleep; // see [R8] see [R11]
          st_q <= rel_now ? ST_EVAL : (flag_q ? ST_HOLD : ST_RUN); // see [R11] see [R22]
        end
        ST_EVAL: begin
          st_q <= flag_q ? ST_HOLD : ST_RUN; // see [R13]
        end
        default: st_q <= ST_RUN;
      endcase
    end
  end

  // Pin snapshot, frozen while parked in sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_q <= '0;
    end else if (flag_set || st_q == ST_EVAL) begin
      snap_q <= pins; // see [R23]
    end
  end

  // Removal then attach tracking
  logic rem_seen_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_seen_q <= 1'b0;
    end else if (removal_evt) begin
      rem_seen_q <= 1'b1;
    end else if (attach_evt) begin
      rem_seen_q <= 1'b0;
    end
  end

  // Fault handling
  logic latch_mode;
  logic err_q;
  logic ppe_prev_q;

  assign latch_mode = smb_q ? lcfg_q : latch_pin_s; // see [R19]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
      ppe_prev_q <= 1'b0;
    end else begin
      ppe_prev_q <= pins.port_power_enable;
      if (|faults) begin
        err_q <= 1'b1; // see [R20]
      end else if (!latch_mode || err_clr || (ppe_prev_q && !pins.port_power_enable)) begin
        err_q <= 1'b0; // see [R19]
      end
    end
  end

  // Registered outputs
  logic alert_n_q, mode_reeval_q, emul_restart_q, monitor_stop_q, latch_mode_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_n_q <= 1'b1;
      mode_reeval_q <= 1'b0;
      emul_restart_q <= 1'b0;
      monitor_stop_q <= 1'b0;
      latch_mode_q <= 1'b0;
    end else begin
      alert_n_q <= !(alert_q || err_q || other_alert); // see [R16]
      mode_reeval_q <= st_q == ST_EVAL; // see [R11] see [R15]
      emul_restart_q <= (st_q == ST_EVAL && pins != snap_q && pins.emulation_enable)
                        || (attach_evt && rem_seen_q && en_q && !flag_q); // see [R13] see [R3]
      monitor_stop_q <= sleep_q; // see [R23]
      latch_mode_q <= latch_mode;
    end
  end

  // APB answer: one wait cycle, unmapped reads zero with error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      if (psel && penable && !pready_q) begin
        if (addr == `CRP_OFS_CTRL) begin
          prdata_q[`CRP_CTRL_EN] <= en_q;
          prdata_q[`CRP_CTRL_BEH_HI:`CRP_CTRL_BEH_LO] <= beh_cfg_q;
          prdata_q[`CRP_CTRL_LATCHCFG] <= lcfg_q;
          prdata_q[`CRP_CTRL_SMBUS] <= smb_q;
        end else if (addr == `CRP_OFS_THRESH) begin
          prdata_q[ACC_W-1:0] <= thr_q;
        end else if (addr == `CRP_OFS_ACCUM) begin
          prdata_q[ACC_W-1:0] <= acc_q;
        end else if (addr == `CRP_OFS_STATUS) begin
          prdata_q[`CRP_STAT_FLAG] <= flag_q;
          prdata_q[`CRP_STAT_ALERT] <= alert_q;
          prdata_q[`CRP_STAT_ERR] <= err_q;
          prdata_q[`CRP_STAT_LATCH] <= latch_mode;
          prdata_q[`CRP_STAT_ST_HI:`CRP_STAT_ST_LO] <= st_q;
          prdata_q[`CRP_STAT_SLEEP] <= sleep_q;
        end else begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign alert_n = alert_n_q;
  assign profile_remove = prof_q;
  assign port_sw_open = sw_q;
  assign bypass_sw_block = sw_q;
  assign sleep_req = sleep_q;
  assign monitor_stop = monitor_stop_q;
  assign mode_reeval = mode_reeval_q;
  assign emul_restart = emul_restart_q;
  assign fault_err = err_q;
  assign fault_latch_mode = latch_mode_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_flag_set_hit: assert property (flag_set |=> flag_q) // see [R24]
    else $error("threshold flag not set on reaching threshold");
  a_flag_only_clr: assert property (flag_q && !flag_clr |=> flag_q) // see [R2]
    else $error("threshold flag dropped without reset or disable");
  a_beh_keeps_acc: assert property (wr_ctrl && !rst_pls && !en_fall && !acc_en
    |=> $stable(acc_q)) // see [R4]
    else $error("behavior write changed accumulated charge");
  a_beh_silent: assert property (st_q == ST_RUN && !flag_set
    |=> beh_q == $past(beh_cfg_q) && !mode_reeval_q) // see [R5]
    else $error("pre-threshold behavior change not silent");
  a_report_alerts: assert property (flag_set && beh_cfg_q == BEH_REPORT
    |-> ##[2:3] !alert_n_q) // see [R21]
    else $error("report behavior did not assert alert");
  a_sleep_order: assert property ($rose(sleep_q) |-> prof_q && sw_q && !alert_q) // see [R8]
    else $error("sleep entered before profile removal and switch open");
  a_sleep_monitor: assert property (sleep_q |=> monitor_stop_q) // see [R23]
    else $error("monitoring not stopped in sleep");
  a_en_clear_acc: assert property (en_fall && !flag_q |=> acc_q == '0) // see [R14]
    else $error("disable before threshold did not clear total");
  a_rst_zero: assert property (rst_pls |=> acc_q == '0) // see [R18]
    else $error("threshold_flag_a reset did not zero total");
  a_disable_release: assert property (flag_clr |-> ##[1:6] !alert_q && !sw_q
    && !sleep_q) // see [R15]
    else $error("disable after threshold did not release actions");
  a_latch_hold: assert property (err_q && latch_mode && !(|faults) && !err_clr
    && !(ppe_prev_q && !pins.port_power_enable) |=> err_q) // see [R19]
    else $error("latched fault cleared without command");

  c_hit_disc: cover property (flag_set && beh_cfg_q == BEH_REP_DISC);
  c_change_reeval: cover property (changed ##[1:6] mode_reeval_q);
  c_restart_attach: cover property (removal_evt ##[1:20] emul_restart_q);

endmodule : crp_charge_threshold_flag_a_ctrl

// ==== test/crp_host_model.sv ====
module crp_host_model import crp_pkg::*; (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Requests from the bench
  input crp_pins_t pins_req,
  input logic pwr_toggle,
  // Pins to the device
  output crp_pins_t mode_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // Host pins change only after a clock edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_pins <= '0;
    end else begin
      mode_pins <= crp_pins_t'(pins_req ^ 5'(pwr_toggle));
    end
  end
endmodule : crp_host_model

// ==== test/tb_crp_charge_threshold_flag_a_ctrl.sv ====
`include "crp_params.svh"
module tb_crp_charge_threshold_flag_a_ctrl import crp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, er, alert_n, profile_remove, port_sw_open, bypass_sw_block;
  logic sleep_req, monitor_stop, mode_reeval, emul_restart, fault_err, fault_latch_mode;
  logic pwr_toggle = 0, latch_pin = 0, active_state = 0, charge_valid = 0;
  logic removal_evt = 0, attach_evt = 0, other_alert = 0;
  logic [5:0] fault_pins = '0;
  logic [7:0] charge_step = '0;
  crp_pins_t pins_req = '0, mode_pins;
  int errors = 0, n_tests = 0, cyc = 0, n_reeval = 0, n_restart = 0, s0 = 0;

  always #2.5 clk = ~clk;

  crp_host_model crp_host_model_inst (.clk(clk), .rst_n(rst_n), .pins_req(pins_req),
    .pwr_toggle(pwr_toggle), .mode_pins(mode_pins));
  crp_charge_threshold_flag_a_ctrl #(.ACC_W(16), .STEP_W(8)) crp_charge_threshold_flag_a_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mode_pins(mode_pins), .latch_pin(latch_pin), .fault_pins(fault_pins),
    .active_state(active_state), .charge_valid(charge_valid), .charge_step(charge_step),
    .removal_evt(removal_evt), .attach_evt(attach_evt), .other_alert(other_alert),
    .alert_n(alert_n), .profile_remove(profile_remove), .port_sw_open(port_sw_open),
    .bypass_sw_block(bypass_sw_block), .sleep_req(sleep_req), .monitor_stop(monitor_stop),
    .mode_reeval(mode_reeval), .emul_restart(emul_restart), .fault_err(fault_err),
    .fault_latch_mode(fault_latch_mode));

  task automatic close_out;
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mode_reeval === 1'b1) n_reeval++;
    if (emul_restart === 1'b1) n_restart++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= 32'(a);
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(nm, rd, exp);
  endtask : rchk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic ctl(input logic [31:0] d);
    apb(1'b1, `CRP_OFS_CTRL, d);
    wt(8);
  endtask : ctl

  task automatic flag(input logic exp);
    apb(1'b0, `CRP_OFS_STATUS, '0);
    chk("flag", 32'(rd[`CRP_STAT_FLAG]), 32'(exp));
  endtask : flag

  task automatic charge(input logic [7:0] s);
    @(posedge clk);
    charge_valid <= 1'b1;
    charge_step <= s;
    @(posedge clk);
    charge_valid <= 1'b0;
  endtask : charge

  task automatic t_reset;
    rchk("ctrl", `CRP_OFS_CTRL, 32'h0000_0012);
    rchk("thresh", `CRP_OFS_THRESH, 32'h0000_FFFF);
    apb(1'b0, 8'h10, '0);
    chk("slverr", 32'(er), 32'h0000_0001);
  endtask : t_reset

  task automatic t_report_chain;
    apb(1'b1, `CRP_OFS_THRESH, 32'h0000_0010);
    ctl(32'h0000_0011);
    charge(8'h08);
    wt(4);
    flag(1'b0);
    charge(8'h08);
    wt(8);
    flag(1'b1);
    chk("report", 32'({alert_n, profile_remove, port_sw_open}), 32'h0000_0000);
    rchk("status", `CRP_OFS_STATUS, 32'h0000_0073);
    ctl(32'h0000_0017);
    chk("alert_n", 32'(alert_n), 32'h0000_0001);
    rchk("accum", `CRP_OFS_ACCUM, 32'h0000_0010);
    ctl(32'h0000_0015);
    chk("sleep", 32'({alert_n, profile_remove, port_sw_open, sleep_req}), 32'h0000_000F);
    chk("monitor", 32'(monitor_stop), 32'h0000_0001);
    chk("reeval", 32'(n_reeval), 32'h0000_0000);
    pins_req <= crp_pins_t'(5'h1D);
    wt(8);
    chk("pins", 32'(sleep_req), 32'h0000_0001);
    s0 = n_restart;
    ctl(32'h0000_0013);
    chk("to_rd", 32'({alert_n, port_sw_open, bypass_sw_block, sleep_req}), 32'h0000_0006);
    chk("restart", 32'(n_restart - s0), 32'h0000_0001);
    chk("reeval", 32'(n_reeval), 32'h0000_0001);
    s0 = n_restart;
    ctl(32'h0000_0113);
    chk("restart", 32'(n_restart - s0), 32'h0000_0000);
    chk("reeval", 32'(n_reeval), 32'h0000_0002);
    rchk("accum", `CRP_OFS_ACCUM, 32'h0000_0000);
    flag(1'b0);
    chk("alert_n", 32'(alert_n), 32'h0000_0001);
  endtask : t_report_chain

  task automatic t_rd_disable;
    charge(8'h10);
    wt(8);
    chk("rd", 32'({alert_n, profile_remove, port_sw_open, sleep_req}), 32'h0000_0006);
    other_alert <= 1'b1;
    ctl(32'h0000_0012);
    flag(1'b0);
    chk("reeval", 32'(n_reeval), 32'h0000_0003);
    chk("alert_n", 32'(alert_n), 32'h0000_0000);
    other_alert <= 1'b0;
    wt(4);
    chk("alert_n", 32'(alert_n), 32'h0000_0001);
    pwr_toggle <= 1'b1;
    wt(4);
    pwr_toggle <= 1'b0;
  endtask : t_rd_disable

  task automatic t_before;
    ctl(32'h0000_0117);
    charge(8'h08);
    rchk("accum", `CRP_OFS_ACCUM, 32'h0000_0008);
    ctl(32'h0000_0117);
    rchk("accum", `CRP_OFS_ACCUM, 32'h0000_0000);
    charge(8'h04);
    active_state <= 1'b0;
    charge(8'h04);
    active_state <= 1'b1;
    rchk("accum", `CRP_OFS_ACCUM, 32'h0000_0004);
    ctl(32'h0000_0011);
    chk("alert_n", 32'(alert_n), 32'h0000_0001);
    s0 = n_restart;
    @(posedge clk);
    removal_evt <= 1'b1;
    @(posedge clk);
    removal_evt <= 1'b0;
    wt(3);
    attach_evt <= 1'b1;
    @(posedge clk);
    attach_evt <= 1'b0;
    wt(4);
    chk("restart", 32'(n_restart - s0), 32'h0000_0001);
    rchk("accum", `CRP_OFS_ACCUM, 32'h0000_0004);
    ctl(32'h0000_0010);
    rchk("accum", `CRP_OFS_ACCUM, 32'h0000_0000);
  endtask : t_before

  task automatic t_faults;
    for (int i = 0; i < 6; i++) begin
      fault_pins <= 6'(1 << i);
      wt(6);
      chk("fault", 32'(fault_err), 32'h0000_0001);
      fault_pins <= '0;
      wt(6);
      chk("auto", 32'(fault_err), 32'h0000_0000);
    end
    ctl(32'h0000_0018);
    chk("latchmode", 32'(fault_latch_mode), 32'h0000_0001);
    fault_pins <= 6'h01;
    wt(6);
    fault_pins <= '0;
    wt(6);
    chk("latched", 32'(fault_err), 32'h0000_0001);
    ctl(32'h0000_0218);
    chk("errclr", 32'(fault_err), 32'h0000_0000);
    fault_pins <= 6'h01;
    wt(6);
    fault_pins <= '0;
    wt(6);
    chk("latched", 32'(fault_err), 32'h0000_0001);
    pwr_toggle <= 1'b1;
    wt(4);
    pwr_toggle <= 1'b0;
    wt(6);
    chk("ppeclr", 32'(fault_err), 32'h0000_0000);
    ctl(32'h0000_0000);
    latch_pin <= 1'b1;
    wt(6);
    chk("pinmode", 32'(fault_latch_mode), 32'h0000_0001);
    latch_pin <= 1'b0;
    wt(6);
    chk("pinmode", 32'(fault_latch_mode), 32'h0000_0000);
  endtask : t_faults

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    active_state <= 1'b1;
    pins_req <= crp_pins_t'(5'h15);
    wt(4);
    t_reset();
    t_report_chain();
    t_rd_disable();
    t_before();
    t_faults();
    close_out();
  end
endmodule : tb_crp_charge_threshold_flag_a_ctrl
